//--- rtl/rtcu_pkg.sv
// What this block does
// - Left rotate shifts the file value left, old carry into bit 0, old bit 7 into carry.
// - Right rotate shifts the file value right, old carry into bit 7, old bit 0 into carry.
// - With destination bit 0 the result goes to the accumulator and the file stays as is.
// - With destination bit 1 a left rotate writes the result back to its source register.
// - With destination bit 1 a right rotate writes the result back to its source register.
package rtcu_pkg;

    localparam int          DATA_W      = 8;
    localparam int          ADDR_W      = 5;
    localparam int          OPC_W       = 12;
    localparam int          CARRY_BIT   = 0;
    localparam int          DEST_BIT    = 5;
    localparam int          TOP_HI      = 11;
    localparam int          TOP_LO      = 6;
    localparam logic [5:0]  OPC_ROT_L   = 6'h0D;
    localparam logic [5:0]  OPC_ROT_R   = 6'h0C;
    localparam logic [7:0]  ACC_RESET   = 8'h00;
    localparam logic        CARRY_RESET = 1'b0;

    typedef enum logic [1:0]
    {
        RTCU_NONE  = 2'b00,
        RTCU_LEFT  = 2'b01,
        RTCU_RIGHT = 2'b10
    } rtcu_op_e;

    // File write port bundle
    typedef struct packed
    {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } rtcu_fwr_s;

    function automatic logic [DATA_W:0] rtcu_rotate(
        input rtcu_op_e          op,
        input logic [DATA_W-1:0] val,
        input logic              cin
    );
        // Returns {carry_out, result}
        if (op == RTCU_LEFT)
            return {val[DATA_W-1], val[DATA_W-2:0], cin};
        else
            return {val[0], cin, val[DATA_W-1:1]};
    endfunction : rtcu_rotate

endpackage : rtcu_pkg

//--- rtl/rtcu_rotate_unit.sv
`timescale 1ns/100ps
module rtcu_rotate_unit
(
    input  wire logic                           clk,
    input  wire logic                           srst,
    input  wire logic                           ce,
    input  wire logic [rtcu_pkg::OPC_W-1:0]     opcode,
    input  wire logic                           opcode_valid,
    input  wire logic [rtcu_pkg::DATA_W-1:0]    file_rd_data,
    output logic      [rtcu_pkg::ADDR_W-1:0]    file_rd_addr,
    output rtcu_pkg::rtcu_fwr_s                 file_wr,
    output logic      [rtcu_pkg::DATA_W-1:0]    acc_ff,
    output logic                                acc_wr_ff,
    output logic                                carry_ff,
    output logic                                done_ff
);
    import rtcu_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Decode; the file read is combinational so the op finishes in one cycle
    wire logic [5:0]        op_top   = opcode[TOP_HI:TOP_LO];
    wire logic              dest_sel = opcode[DEST_BIT];
    wire rtcu_op_e          op       = !opcode_valid ? RTCU_NONE :
                                       (op_top == OPC_ROT_L) ? RTCU_LEFT :
                                       (op_top == OPC_ROT_R) ? RTCU_RIGHT :
                                       RTCU_NONE;
    wire logic              is_rot   = (op != RTCU_NONE);
    wire logic [DATA_W:0]   rot      = rtcu_rotate(op, file_rd_data, carry_ff);

    assign file_rd_addr = opcode[ADDR_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    rtcu_fwr_s wr_ff;
    assign file_wr = wr_ff;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            acc_ff    <= ACC_RESET;
            acc_wr_ff <= 1'b0;
            carry_ff  <= CARRY_RESET;
            done_ff   <= 1'b0;
            wr_ff     <= '0;
        end
        else if (ce)
        begin
            done_ff   <= is_rot;
            acc_wr_ff <= is_rot && !dest_sel;
            wr_ff.en  <= is_rot && dest_sel;
            wr_ff.addr <= opcode[ADDR_W-1:0];
            wr_ff.data <= rot[DATA_W-1:0];
            if (is_rot)
                carry_ff <= rot[DATA_W];
            if (is_rot && !dest_sel)
                acc_ff <= rot[DATA_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    left_result_a: assert property (@(posedge clk) disable iff (srst)
        ce && op == RTCU_LEFT && !dest_sel |=>
        acc_ff == {$past(file_rd_data[6:0]), $past(carry_ff)} && carry_ff == $past(file_rd_data[7]))
        else $error("left rotate result wrong");
    right_result_a: assert property (@(posedge clk) disable iff (srst)
        ce && op == RTCU_RIGHT && dest_sel |=>
        file_wr.data == {$past(carry_ff), $past(file_rd_data[7:1])} && carry_ff == $past(file_rd_data[0]))
        else $error("right rotate result wrong");
    acc_dest_a: assert property (@(posedge clk) disable iff (srst)
        ce && is_rot && !dest_sel |=> acc_wr_ff && !file_wr.en)
        else $error("accumulator destination wrong");
    left_back_a: assert property (@(posedge clk) disable iff (srst)
        ce && op == RTCU_LEFT && dest_sel |=>
        file_wr.en && file_wr.addr == $past(opcode[4:0]) && !acc_wr_ff && $stable(acc_ff))
        else $error("left write back wrong");
    right_back_a: assert property (@(posedge clk) disable iff (srst)
        ce && op == RTCU_RIGHT && dest_sel |=>
        file_wr.en && file_wr.addr == $past(opcode[4:0]) && !acc_wr_ff)
        else $error("right write back wrong");
    one_cycle_a: assert property (@(posedge clk) disable iff (srst)
        ce && opcode_valid && opcode[11:7] == 5'h06 |=> done_ff)
        else $error("rotate did not finish in one cycle");
    no_op_a: assert property (@(posedge clk) disable iff (srst)
        ce && !is_rot |=> !done_ff && !file_wr.en && !acc_wr_ff && $stable(carry_ff))
        else $error("non-rotate opcode had effect");
    freeze_a: assert property (@(posedge clk) disable iff (srst)
        !ce |=> $stable(acc_ff) && $stable(carry_ff) && $stable(done_ff))
        else $error("state moved while clock enable low");

endmodule : rtcu_rotate_unit

//--- tb/rtcu_rotate_unit_tb.sv
`timescale 1ns/100ps
module rtcu_rotate_unit_tb;
    import rtcu_pkg::*;
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin miscompares++; \
    $display("[FAIL] %s exp %h seen %h", n, e, s); end end
    logic              clk = 1'b0, srst = 1'b1, ce = 1'b0, opcode_valid = 1'b0;
    logic [OPC_W-1:0]  opcode = '0;
    logic [DATA_W-1:0] mem [32];
    logic [DATA_W-1:0] file_rd_data, acc_ff, e_acc, res;
    logic [ADDR_W-1:0] file_rd_addr;
    rtcu_fwr_s         file_wr, e_wr;
    logic              acc_wr_ff, carry_ff, done_ff, e_awr, e_c, e_done, hit;
    int                miscompares = 0, n_tests = 0, seed = 45, r;
    // File is combinational, as the core's register file would be
    assign file_rd_data = mem[file_rd_addr];
    rtcu_rotate_unit rtcu_rotate_unit_i (.clk(clk), .srst(srst), .ce(ce), .opcode(opcode),
        .opcode_valid(opcode_valid), .file_rd_data(file_rd_data), .file_rd_addr(file_rd_addr),
        .file_wr(file_wr), .acc_ff(acc_ff), .acc_wr_ff(acc_wr_ff), .carry_ff(carry_ff),
        .done_ff(done_ff));
    initial forever #2 clk = ~clk;
////////////////////////////////////////////////////////////////////////////////
    task automatic check();
        `CHK("rd_addr", opcode[4:0], file_rd_addr)
        `CHK("acc", e_acc, acc_ff)
        `CHK("carry", e_c, carry_ff)
        `CHK("acc_wr", e_awr, acc_wr_ff)
        `CHK("done", e_done, done_ff)
        `CHK("wr_en", e_wr.en, file_wr.en)
        // Write lands after the edge, so the model file follows it here
        if (e_wr.en)
        begin
            `CHK("wr", e_wr, file_wr)
            mem[e_wr.addr] = e_wr.data;
        end
    endtask : check
    task automatic drive(input logic [11:0] op, input logic v, input logic c);
        logic [7:0] val;
        val = mem[op[4:0]];
        opcode = op;
        opcode_valid = v;
        ce = c;
        hit = v && c && (op[11:7] == 5'h06);
        if (c)
        begin
            {e_awr, e_done, e_wr.en} = {1'b0, hit, 1'b0};
        end
        if (hit)
        begin
            res = op[6] ? {val[6:0], e_c} : {e_c, val[7:1]};
            e_c = op[6] ? val[7] : val[0];
            if (op[5])
                e_wr = {1'b1, op[4:0], res};
            else
                {e_acc, e_awr} = {res, 1'b1};
        end
    endtask : drive
    task automatic close_out();
        $display("Comparisons %0d, miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int i = 0; i < 32; i++) mem[i] = 8'($random(seed));
        mem[5'h1A] = 8'hE6;
        mem[5'h01] = 8'hE6;
        {e_acc, e_c, e_awr, e_done, e_wr} = '0;
        repeat (16) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        check();
        // Back-to-back: right to accumulator, then left to accumulator
        drive(12'h301, 1'b1, 1'b1);
        @(negedge clk);
        check();
        drive(12'h35A, 1'b1, 1'b1);
        repeat (1500)
        begin
            @(negedge clk);
            check();
            r = $random(seed);
            drive({r[1:0] == 2'h0 ? r[13:8] : {5'h06, r[2]}, r[19:14]}, r[3] | r[4], |r[7:5]);
        end
        @(negedge clk);
        check();
        close_out();
    end
    initial
    begin
        #(4 * 2000);
        miscompares++;
        close_out();
    end
endmodule : rtcu_rotate_unit_tb
